// file: common/esg_pkg.sv
// Purpose: Shared constants and types for the external step/direction gearing unit.
// Assumes: APB register indices; byte address is four times the index.
// Notes:   Gearing factor is signed 8.24 fixed point.
package esg_pkg;

	localparam int unsigned ADDR_W    = 12;
	localparam int unsigned DATA_W    = 32;
	localparam int unsigned FRAC_BITS = 24;
	localparam int unsigned PHASE_W   = 16;
	localparam int unsigned PEND_W    = 16;

	// Register indices
	localparam logic [9:0] IDX_GENERAL_CONFIGURATION   = 10'h000;
	localparam logic [9:0] IDX_ELECTRONIC_GEARING      = 10'h012;
	localparam logic [9:0] IDX_CURRENT_POSITION        = 10'h021;
	localparam logic [9:0] IDX_CURRENT_VELOCITY        = 10'h022;
	localparam logic [9:0] IDX_START_VELOCITY          = 10'h025;
	localparam logic [9:0] IDX_START_ACCELERATION      = 10'h02a;
	localparam logic [9:0] IDX_TARGET_POSITION         = 10'h037;
	localparam logic [9:0] IDX_STEP_STATUS             = 10'h038;

	// General configuration fields, plus the start acceleration sign bit
	localparam int unsigned SDIN_MODE_LSB   = 6;
	localparam int unsigned POL_DIR_IN_BIT  = 8;
	localparam int unsigned INDIRECT_BIT    = 9;
	localparam int unsigned AUTO_SWITCH_BIT = 26;
	localparam int unsigned ACC_SIGN_BIT    = 31;

	// Status fields
	localparam int unsigned ST_EXT_ACTIVE_BIT = 0;
	localparam int unsigned ST_LAST_DIR_BIT   = 1;
	localparam int unsigned ST_HANDOVER_BIT   = 2;

	// Reset values
	localparam logic [31:0] GENERAL_CONFIGURATION_RST = 32'h0000_0000;
	localparam logic [31:0] GEARING_FACTOR_RST        = 32'h0100_0000;
	localparam logic [31:0] START_VELOCITY_RST        = 32'h0000_0000;
	localparam logic [31:0] START_ACCELERATION_RST    = 32'h0000_0000;

	typedef enum logic [1:0] {
		SDIN_INTERNAL = 2'b00,
		SDIN_RISE     = 2'b01,
		SDIN_FALL     = 2'b10,
		SDIN_BOTH     = 2'b11
	} esg_sdin_mode_type;

	typedef enum logic [1:0] {
		CTRL_INTERNAL = 2'b00,
		CTRL_DIRECT   = 2'b01,
		CTRL_INDIRECT = 2'b10
	} esg_ctrl_state_type;

	typedef struct packed {
		logic signed [31:0]        velocity;
		logic signed [31:0]        acceleration;
		logic [PHASE_W-1:0]        step_phase;
	} esg_handover_type;

endpackage

// file: rtl/esg_step_input.sv
// Purpose: Synchronise step and direction inputs and detect the selected step edge.
// Assumes: Inputs may be asynchronous to clk_i.
// Notes:   First sync stage feeds only the second stage.
module esg_step_input
	import esg_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              ce_i,
	input  wire esg_sdin_mode_type mode_i,
	input  wire logic              step_input_pin_i,
	input  wire logic              direction_input_pin_i,
	output logic                   ext_step_o,
	output logic                   dir_level_o
);
	logic [1:0] step_sync;
	logic [1:0] dir_sync;
	logic       step_prev;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			step_sync <= 2'h0;
			dir_sync  <= 2'h0;
			step_prev <= 1'b0;
		end else if (ce_i) begin
			step_sync <= {step_sync[0], step_input_pin_i};
			dir_sync  <= {dir_sync[0], direction_input_pin_i};
			step_prev <= step_sync[1];
		end
	end

	always_comb begin
		dir_level_o = dir_sync[1];
		unique case (mode_i)
			SDIN_RISE:     ext_step_o = step_sync[1] & ~step_prev;
			SDIN_FALL:     ext_step_o = ~step_sync[1] & step_prev;
			SDIN_BOTH:     ext_step_o = step_sync[1] ^ step_prev;
			SDIN_INTERNAL: ext_step_o = 1'b0;
		endcase
	end
endmodule

// file: rtl/esg_gearing.sv
// Purpose: Fixed-point gearing accumulator turning external steps into internal steps.
// Assumes: One external step pulse at most per cycle.
// Notes:   Carries beyond one are queued and emitted one per cycle.
module esg_gearing
	import esg_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        ce_i,
	input  wire logic        ext_step_i,
	input  wire logic        positive_i,
	input  wire logic [31:0] gear_i,
	output logic             int_step_o,
	output logic             int_dir_o
);
	logic [FRAC_BITS-1:0]     frac;
	logic signed [PEND_W-1:0] pending;
	logic [31:0]              magnitude;
	logic [32:0]              sum;
	logic signed [PEND_W-1:0] carry;
	logic signed [PEND_W-1:0] emit;
	logic                     gear_positive;

	always_comb begin
		magnitude     = gear_i[31] ? (~gear_i + 32'h0000_0001) : gear_i;
		sum           = {9'h000, frac} + {1'b0, magnitude};
		gear_positive = positive_i ^ gear_i[31];
		carry         = ext_step_i ? PEND_W'(sum[32:FRAC_BITS]) : PEND_W'(0);
		if (!gear_positive)
			carry = -carry;
		if (pending > 0)
			emit = PEND_W'(1);
		else if (pending < 0)
			emit = -PEND_W'(1);
		else
			emit = PEND_W'(0);
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			frac <= '0;
		end else if (ce_i && ext_step_i) begin
			frac <= sum[FRAC_BITS-1:0];
		end
	end

	// Queue lets a large ratio burst steps without interpolation
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pending    <= '0;
			int_step_o <= 1'b0;
			int_dir_o  <= 1'b0;
		end else if (ce_i) begin
			pending    <= pending + carry - emit;
			int_step_o <= (pending != 0);
			if (pending != 0)
				int_dir_o <= (pending > 0);
		end
	end
endmodule

// file: rtl/esg_unit.sv
// Purpose: Step/direction input unit with electronic gearing and ramp handover.
// Assumes: APB slave, 32-bit words, byte address = register index times four.
// Notes:   One cycle of wait state on every APB access; ce_i low freezes all state.
module esg_unit
	import esg_pkg::*;
(
	input  wire logic                      clk_i,
	input  wire logic                      reset_n_i,
	input  wire logic                      ce_i,
	input  wire logic                      psel_i,
	input  wire logic                      penable_i,
	input  wire logic                      pwrite_i,
	input  wire logic [esg_pkg::ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]               pwdata_i,
	output logic [31:0]                    prdata_o,
	output logic                           pready_o,
	output logic                           pslverr_o,
	input  wire logic                      step_input_pin_i,
	input  wire logic                      direction_input_pin_i,
	input  wire logic                      ramp_step_i,
	input  wire logic                      ramp_dir_i,
	input  wire logic signed [31:0]        ramp_velocity_i,
	output logic                           internal_generator_enable_o,
	output logic                           step_output_pin_o,
	output logic                           direction_output_o,
	output logic                           ramp_load_o,
	output esg_pkg::esg_handover_type      ramp_load_o_data_o
);
	import esg_pkg::*;

	function automatic logic idx_hit(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
		idx_hit = (addr[1:0] == 2'b00) && (addr[ADDR_W-1:2] == idx);
	endfunction

	logic [31:0]              general_configuration;
	logic [31:0]              electronic_gearing_factor;
	logic [31:0]              start_velocity;
	logic [31:0]              start_acceleration;
	logic signed [31:0]       current_position;
	logic signed [31:0]       target_position;
	logic signed [31:0]       current_velocity;
	esg_ctrl_state_type       ctrl_state;
	esg_ctrl_state_type       next_ctrl_state;
	logic                     last_dir;
	logic                     handover_seen;
	logic [PHASE_W-1:0]       step_phase;
	esg_sdin_mode_type        sdin_mode;
	logic                     pol_dir_in;
	logic                     indirect_target_mode;
	logic                     auto_switch;
	logic                     ext_step;
	logic                     dir_level;
	logic                     int_step;
	logic                     int_dir;
	logic                     access;
	logic                     wr_en;
	logic                     mapped;
	logic [31:0]              rd_value;
	logic [31:0]              status_word;
	logic                     handover_now;

	//////////////////////////////////////////////////////////////////////////////////////
	// Configuration decode

	always_comb begin
		sdin_mode            = esg_sdin_mode_type'(general_configuration[SDIN_MODE_LSB +: 2]);
		pol_dir_in           = general_configuration[POL_DIR_IN_BIT];
		indirect_target_mode = general_configuration[INDIRECT_BIT];
		auto_switch          = general_configuration[AUTO_SWITCH_BIT];
	end

	esg_step_input u_step_input (
		.clk_i                 (clk_i),
		.reset_n_i             (reset_n_i),
		.ce_i                  (ce_i),
		.mode_i                (sdin_mode),
		.step_input_pin_i      (step_input_pin_i),
		.direction_input_pin_i (direction_input_pin_i),
		.ext_step_o            (ext_step),
		.dir_level_o           (dir_level)
	);

	// Level 0 means negative unless polarity inverted
	esg_gearing u_gearing (
		.clk_i      (clk_i),
		.reset_n_i  (reset_n_i),
		.ce_i       (ce_i),
		.ext_step_i (ext_step),
		.positive_i (dir_level ^ pol_dir_in),
		.gear_i     (electronic_gearing_factor),
		.int_step_o (int_step),
		.int_dir_o  (int_dir)
	);

	//////////////////////////////////////////////////////////////////////////////////////
	// APB slave

	always_comb begin
		access = psel_i && penable_i && !pready_o;
		wr_en  = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
		mapped = idx_hit(paddr_i, IDX_GENERAL_CONFIGURATION) ||
			idx_hit(paddr_i, IDX_ELECTRONIC_GEARING) ||
			idx_hit(paddr_i, IDX_START_VELOCITY) ||
			idx_hit(paddr_i, IDX_START_ACCELERATION) ||
			idx_hit(paddr_i, IDX_CURRENT_POSITION) ||
			idx_hit(paddr_i, IDX_CURRENT_VELOCITY) ||
			idx_hit(paddr_i, IDX_TARGET_POSITION) ||
			idx_hit(paddr_i, IDX_STEP_STATUS);
		status_word                    = 32'h0000_0000;
		status_word[ST_EXT_ACTIVE_BIT] = (ctrl_state != CTRL_INTERNAL);
		status_word[ST_LAST_DIR_BIT]   = last_dir;
		status_word[ST_HANDOVER_BIT]   = handover_seen;
		rd_value = 32'h0000_0000;
		if (idx_hit(paddr_i, IDX_GENERAL_CONFIGURATION))
			rd_value = general_configuration;
		if (idx_hit(paddr_i, IDX_ELECTRONIC_GEARING))
			rd_value = electronic_gearing_factor;
		if (idx_hit(paddr_i, IDX_START_VELOCITY))
			rd_value = start_velocity;
		if (idx_hit(paddr_i, IDX_START_ACCELERATION))
			rd_value = start_acceleration;
		if (idx_hit(paddr_i, IDX_CURRENT_POSITION))
			rd_value = current_position;
		if (idx_hit(paddr_i, IDX_CURRENT_VELOCITY))
			rd_value = current_velocity;
		if (idx_hit(paddr_i, IDX_TARGET_POSITION))
			rd_value = target_position;
		if (idx_hit(paddr_i, IDX_STEP_STATUS))
			rd_value = status_word;
	end

	// One wait state keeps pready and prdata registered
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end else if (ce_i) begin
			pready_o  <= access;
			pslverr_o <= access && !mapped;
			if (access)
				prdata_o <= pwrite_i ? 32'h0000_0000 : rd_value;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			general_configuration     <= GENERAL_CONFIGURATION_RST;
			electronic_gearing_factor <= GEARING_FACTOR_RST;
			start_velocity            <= START_VELOCITY_RST;
			start_acceleration        <= START_ACCELERATION_RST;
		end else if (ce_i && wr_en) begin
			if (idx_hit(paddr_i, IDX_GENERAL_CONFIGURATION))
				general_configuration <= pwdata_i;
			if (idx_hit(paddr_i, IDX_ELECTRONIC_GEARING))
				electronic_gearing_factor <= pwdata_i;
			if (idx_hit(paddr_i, IDX_START_VELOCITY))
				start_velocity <= pwdata_i;
			if (idx_hit(paddr_i, IDX_START_ACCELERATION))
				start_acceleration <= pwdata_i;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// Control state

	always_comb begin
		if (sdin_mode == SDIN_INTERNAL)
			next_ctrl_state = CTRL_INTERNAL;
		else if (indirect_target_mode)
			next_ctrl_state = CTRL_INDIRECT;
		else
			next_ctrl_state = CTRL_DIRECT;
		// Start acceleration of zero is left to software for a plain handover
		handover_now = (ctrl_state == CTRL_DIRECT) && (next_ctrl_state == CTRL_INTERNAL) &&
			auto_switch;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_state <= CTRL_INTERNAL;
		end else if (ce_i) begin
			ctrl_state <= next_ctrl_state;
		end
	end

	// Direction of the last external motion, used for velocity sign
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			last_dir <= 1'b1;
		end else if (ce_i && int_step) begin
			last_dir <= int_dir;
		end
	end

	// Saturating age of the last internal step taken in direct mode
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			step_phase <= '0;
		end else if (ce_i) begin
			if (int_step && ctrl_state == CTRL_DIRECT)
				step_phase <= '0;
			else if (step_phase != '1)
				step_phase <= step_phase + PHASE_W'(1);
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// Position, target and velocity

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			current_position <= '0;
		end else if (ce_i) begin
			unique case (ctrl_state)
				CTRL_DIRECT: begin
					if (int_step)
						current_position <= int_dir ? current_position + 32'sd1
							: current_position - 32'sd1;
				end
				CTRL_INTERNAL, CTRL_INDIRECT: begin
					if (ramp_step_i)
						current_position <= ramp_dir_i ? current_position + 32'sd1
							: current_position - 32'sd1;
				end
				default: current_position <= current_position;
			endcase
		end
	end

	// The far end keeps indirect steps 64 cycles apart; the queue absorbs closer ones
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			target_position <= '0;
		end else if (ce_i && ctrl_state == CTRL_INDIRECT && int_step) begin
			target_position <= int_dir ? target_position + 32'sd1
				: target_position - 32'sd1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			current_velocity <= '0;
		end else if (ce_i) begin
			if (ctrl_state == CTRL_INTERNAL || ctrl_state == CTRL_INDIRECT)
				current_velocity <= ramp_velocity_i;
			else if (auto_switch)
				current_velocity <= last_dir ? $signed(start_velocity)
					: -$signed(start_velocity);
			else
				current_velocity <= '0;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// Outputs

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			internal_generator_enable_o <= 1'b1;
			step_output_pin_o           <= 1'b0;
			direction_output_o          <= 1'b0;
		end else if (ce_i) begin
			// Held off one more cycle if a direct step leaves at the handover edge
			internal_generator_enable_o <= (next_ctrl_state != CTRL_DIRECT) &&
				!(int_step && ctrl_state == CTRL_DIRECT);
			step_output_pin_o           <= int_step && ctrl_state == CTRL_DIRECT;
			if (int_step && ctrl_state == CTRL_DIRECT)
				direction_output_o <= int_dir;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ramp_load_o        <= 1'b0;
			ramp_load_o_data_o <= '0;
			handover_seen      <= 1'b0;
		end else if (ce_i) begin
			ramp_load_o <= handover_now;
			if (handover_now) begin
				handover_seen <= 1'b1;
				ramp_load_o_data_o.velocity <= last_dir ? $signed(start_velocity)
					: -$signed(start_velocity);
				ramp_load_o_data_o.acceleration <= start_acceleration[ACC_SIGN_BIT]
					? -$signed({1'b0, start_acceleration[30:0]})
					: $signed({1'b0, start_acceleration[30:0]});
				ramp_load_o_data_o.step_phase <= step_phase;
			end else if (next_ctrl_state != CTRL_INTERNAL) begin
				handover_seen <= 1'b0;
			end
		end
	end
endmodule

// file: tb/esg_pulse_src.sv
// Purpose: Far-side controller model driving step and direction pins.
// Assumes: send is called just after a rising clock edge.
// Notes:   Step line idles low; direction is held for a whole burst.
module esg_pulse_src (
	input  wire logic clk_i,
	output logic      step_o,
	output logic      dir_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		step_o = 1'h0;
		dir_o = 1'h0;
	end

	// Each level held 32 cycles or more, so steps stay 64 apart
	task automatic send(input int n, input int half, input logic d);
		int h;
		h = (half < 32) ? 32 : half;
		dir_o <= d;
		repeat (h) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			step_o <= 1'h1;
			repeat (h) @(posedge clk_i);
			step_o <= 1'h0;
			repeat (h) @(posedge clk_i);
		end
	endtask
endmodule

// file: tb/esg_unit_props.sv
// Purpose: Port-level checks for the step/direction gearing unit.
// Assumes: Register contents are mirrored from completed APB writes.
// Notes:   Edge check only with unity gearing, where one step gives one pulse.
module esg_unit_props
	import esg_pkg::*;
(
	input wire logic                       clk_i,
	input wire logic                       reset_n_i,
	input wire logic                       psel_i,
	input wire logic                       penable_i,
	input wire logic                       pwrite_i,
	input wire logic [esg_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [31:0]                pwdata_i,
	input wire logic                       pready_o,
	input wire logic                       step_input_pin_i,
	input wire logic                       direction_input_pin_i,
	input wire logic                       internal_generator_enable_o,
	input wire logic                       step_output_pin_o,
	input wire logic                       direction_output_o,
	input wire logic                       ramp_load_o,
	input wire esg_pkg::esg_handover_type  ramp_load_o_data_o
);
	logic [31:0] cfg, gear, sv, sa;
	logic [3:0]  age;
	logic [15:0] ph;
	logic        last_pos;
	logic        wr;

	assign wr = psel_i && penable_i && pready_o && pwrite_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cfg <= GENERAL_CONFIGURATION_RST;
			gear <= GEARING_FACTOR_RST;
			sv <= START_VELOCITY_RST;
			sa <= START_ACCELERATION_RST;
		end else if (wr) begin
			case (paddr_i)
				{IDX_GENERAL_CONFIGURATION, 2'h0}: cfg <= pwdata_i;
				{IDX_ELECTRONIC_GEARING, 2'h0}: gear <= pwdata_i;
				{IDX_START_VELOCITY, 2'h0}: sv <= pwdata_i;
				{IDX_START_ACCELERATION, 2'h0}: sa <= pwdata_i;
				default: ;
			endcase
		end
	end

	// Settling age guards checks against mode changes in flight
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			age <= 4'h0;
			ph <= 16'h0000;
			last_pos <= 1'h1;
		end else begin
			age <= (wr && paddr_i == 12'h000) ? 4'h0 : ((age == 4'hf) ? age : age + 4'h1);
			ph <= step_output_pin_o ? 16'h0000 : ((ph == 16'hffff) ? ph : ph + 16'h0001);
			if (step_output_pin_o)
				last_pos <= direction_output_o;
		end
	end

	////////////////////////////////////////////////////////////////
	property p_gen_off;
		age == 4'hf |-> internal_generator_enable_o == !(cfg[7:6] != 2'h0 && !cfg[9]);
	endproperty
	a_gen_off: assert property (p_gen_off) else $error("generator enable wrong");
	property p_edge;
		(age == 4'hf && !cfg[9] && gear == 32'h0100_0000
			&& ((cfg[7:6] == 2'h1 && $rose(step_input_pin_i))
			|| (cfg[7:6] == 2'h2 && $fell(step_input_pin_i))
			|| (cfg[7:6] == 2'h3 && $changed(step_input_pin_i)))) |-> ##[3:7] step_output_pin_o;
	endproperty
	a_edge: assert property (p_edge) else $error("selected edge gave no step");
	property p_dir;
		step_output_pin_o && age == 4'hf
			|-> direction_output_o == (direction_input_pin_i ^ cfg[8] ^ gear[31]);
	endproperty
	a_dir: assert property (p_dir) else $error("step direction wrong");
	property p_only_direct;
		step_output_pin_o |-> !internal_generator_enable_o;
	endproperty
	a_only_direct: assert property (p_only_direct) else $error("step outside direct mode");
	property p_load_time;
		wr && paddr_i == 12'h000 && pwdata_i[7:6] == 2'h0 && cfg[7:6] != 2'h0 && !cfg[9] && cfg[26]
			|-> ##2 ramp_load_o;
	endproperty
	a_load_time: assert property (p_load_time) else $error("handover load missing");
	property p_load_vel;
		ramp_load_o |-> ramp_load_o_data_o.velocity == (last_pos ? sv : -sv);
	endproperty
	a_load_vel: assert property (p_load_vel) else $error("handover velocity wrong");
	property p_load_acc;
		ramp_load_o |-> ramp_load_o_data_o.acceleration
			== (sa[31] ? -{1'h0, sa[30:0]} : {1'h0, sa[30:0]});
	endproperty
	a_load_acc: assert property (p_load_acc) else $error("handover acceleration wrong");
	property p_phase;
		ramp_load_o |-> ({1'h0, ramp_load_o_data_o.step_phase} + 17'h00003 >= {1'h0, ph})
			&& ({1'h0, ph} + 17'h00003 >= {1'h0, ramp_load_o_data_o.step_phase});
	endproperty
	a_phase: assert property (p_phase) else $error("handover step phase wrong");
	property p_apb;
		psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o;
	endproperty
	a_apb: assert property (p_apb) else $error("bus answer timing wrong");
endmodule

bind esg_unit esg_unit_props u_props (
	.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
	.step_input_pin_i, .direction_input_pin_i, .internal_generator_enable_o,
	.step_output_pin_o, .direction_output_o, .ramp_load_o, .ramp_load_o_data_o
);

// file: tb/tb_ext_step_dir_gearing.sv
// Purpose: Self-checking bench for the step/direction gearing unit.
// Assumes: Ramp step inputs held idle, so position moves by external steps only.
// Notes:   Each case starts from reset so the accumulator remainder is zero.
module tb_ext_step_dir_gearing;
	timeunit 1ns;
	timeprecision 1ns;
	import esg_pkg::*;

	logic             clk_i = 1'h0;
	logic             reset_n_i = 1'h0;
	logic             psel_i = 1'h0;
	logic             penable_i = 1'h0;
	logic             pwrite_i = 1'h0;
	logic [11:0]      paddr_i = 12'h000;
	logic [31:0]      pwdata_i = 32'h0;
	logic [31:0]      ramp_velocity_i = 32'h0;
	logic [31:0]      prdata_o;
	logic             pready_o, pslverr_o, internal_generator_enable_o;
	logic             step_output_pin_o, direction_output_o, ramp_load_o;
	esg_handover_type ramp_load_o_data_o, cap;
	wire logic        step_input_pin_i, direction_input_pin_i;
	int               bad_count = 0, num_checks = 0, steps = 0, loads = 0;
	logic [31:0]      seed = 32'h0000_2a9a;
	logic [31:0]      rd;
	logic             er;
	logic [9:0]       rix [4] = '{IDX_GENERAL_CONFIGURATION, IDX_ELECTRONIC_GEARING,
		IDX_START_VELOCITY, IDX_START_ACCELERATION};
	logic [31:0]      rrst [4] = '{GENERAL_CONFIGURATION_RST, GEARING_FACTOR_RST,
		START_VELOCITY_RST, START_ACCELERATION_RST};
	logic [1:0]       md [11] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2};
	logic [31:0]      gr [11] = '{32'h0100_0000, 32'h0100_0000, 32'h0100_0000, 32'h0080_0000,
		32'h0280_0000, 32'hff00_0000, 32'h7f00_0000, 32'h0000_0001, 32'h0, 32'hfd80_0000,
		32'h0100_0000};

	esg_unit dut (
		.clk_i, .reset_n_i, .ce_i(1'h1), .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .step_input_pin_i, .direction_input_pin_i,
		.ramp_step_i(1'h0), .ramp_dir_i(1'h0), .ramp_velocity_i, .internal_generator_enable_o,
		.step_output_pin_o, .direction_output_o, .ramp_load_o, .ramp_load_o_data_o
	);
	esg_pulse_src src (.clk_i, .step_o(step_input_pin_i), .dir_o(direction_input_pin_i));

	always #10 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		if (step_output_pin_o === 1'h1)
			steps++;
		if (ramp_load_o === 1'h1) begin
			loads++;
			cap = ramp_load_o_data_o;
		end
	end

	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Whole internal steps after n external steps from a zero remainder
	function automatic logic [31:0] exp_cnt(input int n, input logic [31:0] g);
		logic [63:0] m;
		m = {32'h0, g[31] ? -g : g} * 64'(n);
		return m[55:24];
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int t;
		psel_i <= 1'h1;
		penable_i <= 1'h0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'h1;
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (pready_o !== 1'h1 && t < 50);
		if (pready_o !== 1'h1)
			bad_count++;
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
		// Idle cycle so the next call never reassigns psel in this time step
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [9:0] i, input logic [31:0] d);
		apb(1'h1, {i, 2'h0}, d);
	endtask

	task automatic rdr(input logic [9:0] i);
		apb(1'h0, {i, 2'h0}, 32'h0);
	endtask

	task automatic rst;
		reset_n_i <= 1'h0;
		repeat (5) @(posedge clk_i);
		reset_n_i <= 1'h1;
		@(posedge clk_i);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		logic [31:0] g, e, v, a, c;
		int n;
		logic d, p, ix, pos;
		rst;
		apb(1'h0, 12'h3fc, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		apb(1'h1, 12'h002, 32'hffff_ffff);
		chk({31'h0, er}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			rdr(rix[i]);
			chk(rd, rrst[i]);
			v = xs();
			wr(rix[i], v);
			rdr(rix[i]);
			chk(rd, v);
		end
		$display("registers done");
		for (int i = 0; i < 11; i++) begin
			rd = xs();
			n = 1 + int'(rd[3:0]) % 6;
			d = rd[4];
			p = rd[5];
			ix = (i >= 9);
			g = xs() & 32'h03ff_ffff;
			if (rd[6])
				g = -g;
			if (i != 8)
				g = gr[i];
			rst;
			ramp_velocity_i <= xs();
			wr(IDX_ELECTRONIC_GEARING, g);
			wr(IDX_GENERAL_CONFIGURATION, {22'h0, ix, p, md[i], 6'h0});
			e = exp_cnt((md[i] == 2'h3) ? 2 * n : n, g);
			steps = 0;
			src.send(n, 32 + int'(xs() & 32'hf), d);
			for (int t = 0; t < 900 && steps < int'(e) && !ix; t++)
				@(posedge clk_i);
			repeat (8) @(posedge clk_i);
			pos = d ^ p ^ g[31];
			chk(steps, ix ? 32'h0 : e);
			rdr(IDX_CURRENT_POSITION);
			chk(rd, ix ? 32'h0 : (pos ? e : -e));
			if (ix) begin
				rdr(IDX_TARGET_POSITION);
				chk(rd, pos ? e : -e);
			end
			rdr(IDX_CURRENT_VELOCITY);
			chk(rd, ix ? ramp_velocity_i : 32'h0);
			chk({31'h0, internal_generator_enable_o}, {31'h0, ix});
			$display("case %0d done", i);
		end
		for (int k = 0; k < 2; k++) begin
			rst;
			rd = xs();
			d = rd[0];
			p = k[0];
			v = xs() & 32'h00ff_ffff;
			// Plain takeover first, then one with a signed start slope
			a = k ? xs() : 32'h0;
			wr(IDX_START_VELOCITY, v);
			wr(IDX_START_ACCELERATION, a);
			c = 32'h0400_0040 | {23'h0, p, 8'h0};
			wr(IDX_GENERAL_CONFIGURATION, c);
			src.send(2, 32, d);
			repeat (10) @(posedge clk_i);
			pos = d ^ p;
			rdr(IDX_CURRENT_VELOCITY);
			chk(rd, pos ? v : -v);
			loads = 0;
			wr(IDX_GENERAL_CONFIGURATION, c & 32'hffff_ff3f);
			repeat (4) @(posedge clk_i);
			chk(loads, 32'h1);
			chk(cap.velocity, pos ? v : -v);
			chk(cap.acceleration, a[31] ? -{1'h0, a[30:0]} : {1'h0, a[30:0]});
			chk({31'h0, internal_generator_enable_o}, 32'h1);
			rdr(IDX_STEP_STATUS);
			chk({29'h0, rd[2:0]}, {29'h0, 1'h1, pos, 1'h0});
			$display("handover %0d done", k);
		end
		wrap_up;
	end

	initial begin
		repeat (60000) @(posedge clk_i);
		bad_count++;
		wrap_up;
	end
endmodule
